// ### inc/tw_pkg.sv
// constants for the two-wire master-send block
// Overview of operation
// (RL1) master mode is entered only after a start; address read/write bit picks the mode
// (RL2) status codes are given with the prescaler bits at zero
// (RL3) software requests start: flag one, start one, stop zero, enable one
// (RL4) start condition waits until the bus is seen free
// (RL5) after start the flag sets with status 0x08
// (RL6) writing one to the flag clears it and resumes the bus step
// (RL7) software loads address with write bit, then clears flag with start and stop zero
// (RL8) after address with write the flag sets with 0x18, 0x20 or 0x38
// (RL9) software writes the data register only while the flag is set
// (RL10) data write with flag clear is dropped and sets the write collision flag
// (RL11) bytes repeat until software requests stop, which sends a stop
// (RL12) repeated start keeps the bus and reports 0x10
// (RL13) in 0x10 address with read enters receive mode, with write stays sending
// (RL14) data byte is sent and acknowledge reported as 0x28 or 0x30
// (RL15) start request while sending makes a repeated start
// (RL16) stop request sends a stop and hardware clears the stop request bit
// (RL17) start and stop requests together send stop then start, stop bit cleared
// (RL18) arbitration loss gives 0x38; clearing without start releases bus to slave mode
// (RL19) in 0x38 clearing with start waits for a free bus and sends start
// (RL20) repeated start changes slave or direction without releasing the bus
// (RL21) while the flag is set the bus transfer stays suspended
// (RL22) software masks status with 0xf8 before comparing
package tw_pkg;
  localparam logic [1:0] ctrl_addr   = 2'h0;
  localparam logic [1:0] status_addr = 2'h1;
  localparam logic [1:0] data_addr   = 2'h2;
  localparam int bit_step   = 7;
  localparam int bit_ack_en = 6;
  localparam int bit_start  = 5;
  localparam int bit_stop   = 4;
  localparam int bit_wcol   = 3;
  localparam int bit_enable = 2;
  localparam int bit_irq_en = 0;
  localparam logic [7:0] ctrl_reset    = 8'h00;
  localparam logic [7:0] status_mask   = 8'hf8;
  localparam logic [7:0] st_idle       = 8'hf8;
  localparam logic [7:0] st_start      = 8'h08;
  localparam logic [7:0] st_rstart     = 8'h10;
  localparam logic [7:0] st_addr_ack   = 8'h18;
  localparam logic [7:0] st_addr_nack  = 8'h20;
  localparam logic [7:0] st_data_ack   = 8'h28;
  localparam logic [7:0] st_data_nack  = 8'h30;
  localparam logic [7:0] st_arb_lost   = 8'h38;
  localparam logic [7:0] st_rx_addr_ack = 8'h40;
  localparam logic [7:0] st_rx_addr_nack = 8'h48;
  localparam logic [2:0] prescale_rst  = 3'h0;
  localparam int half_bit_cycles = 50;
  typedef enum logic [2:0] {op_start, op_stop, op_byte, op_stop_start} op_type;
endpackage

// ### hdl/tw_sync.sv
// two-flop synchroniser for the bus lines
`timescale 1ns/1ps
`default_nettype none
module tw_sync (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  // first flop is read only by the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### hdl/tw_master_send.sv
// two-wire master-send engine with register port
`timescale 1ns/1ps
`default_nettype none
module tw_master_send
  import tw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            recv_mode,
  output logic            slave_mode
);
  typedef enum {s_idle, s_wait_free, s_busy, s_hold} state_type;
  typedef enum {p_a, p_b, p_c, p_d} phase_type;

  ////////////////////////////////////////////////////////////////
  logic scl_s;
  logic sda_s;
  tw_sync u_scl (.clk(clk), .nrst(nrst), .din(scl_in), .dout(scl_s));
  tw_sync u_sda (.clk(clk), .nrst(nrst), .din(sda_in), .dout(sda_s));

  function automatic logic ctrl_hit(input logic [1:0] a, input logic w);
    return w && (a == ctrl_addr);
  endfunction

  logic [7:0] ctrl_q;
  logic [7:0] data_q;
  logic [7:0] status_q;
  state_type  state_q;
  op_type     op_q;
  phase_type  ph_q;
  logic [3:0] bitn_q;
  logic [6:0] tick_q;
  logic       own_q;
  logic       addr_phase_q;
  logic       sda_drv_q;
  logic       scl_drv_q;
  logic       step_done;
  logic       bus_busy_q;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       ack_q;
  logic       arb_lost;
  logic       step_report;

  ////////////////////////////////////////////////////////////////
  wire ctrl_wr  = ctrl_hit(addr, wr);
  wire data_wr  = wr && (addr == data_addr);
  wire clr_step = ctrl_wr && wdata[bit_step];                       // RL6
  wire tick     = (tick_q == 7'(half_bit_cycles - 1));
  // the enable written together with the request counts, not the old one
  wire enabled  = wdata[bit_enable];                                  // RL3
  // a reported step raises the flag; set beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= ctrl_reset;
    end else begin
      if (ctrl_wr) begin
        ctrl_q[bit_ack_en] <= wdata[bit_ack_en];
        ctrl_q[bit_start]  <= wdata[bit_start];
        ctrl_q[bit_stop]   <= wdata[bit_stop];
        ctrl_q[bit_enable] <= wdata[bit_enable];
        ctrl_q[bit_irq_en] <= wdata[bit_irq_en];
        ctrl_q[bit_wcol]   <= 1'b0;
        if (wdata[bit_step])
          ctrl_q[bit_step] <= 1'b0;                                   // RL6
      end
      if (data_wr && !ctrl_q[bit_step])
        ctrl_q[bit_wcol] <= 1'b1;                                     // RL10
      if (step_done && (op_q == op_stop || op_q == op_stop_start))
        ctrl_q[bit_stop] <= 1'b0;                                     // RL16 RL17
      // a stop is not a reported step, so the flag stays down after it
      if (step_report)
        ctrl_q[bit_step] <= 1'b1;                                     // RL5 RL8
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      data_q <= 8'h00;
    else if (data_wr && ctrl_q[bit_step])                              // RL9 RL10
      data_q <= wdata;
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        ctrl_addr:   rdata <= ctrl_q;
        status_addr: rdata <= {status_q[7:3], prescale_rst};           // RL2 RL22
        data_addr:   rdata <= data_q;
        default:     rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus free tracking from start/stop seen on the lines
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
      bus_busy_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (scl_s && scl_p_q && sda_p_q && !sda_s)
        bus_busy_q <= 1'b1;
      else if (scl_s && scl_p_q && !sda_p_q && sda_s)
        bus_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || state_q != s_busy || tick)
      tick_q <= 7'h00;
    else
      tick_q <= tick_q + 7'h01;
  end

  // losing arbitration: we release sda but the line reads low
  assign arb_lost = (state_q == s_busy) && op_q == op_byte && ph_q == p_c && tick
                    && scl_s && bitn_q != 4'h8 && sda_drv_q && !sda_s;    // RL18
  // a byte ends after its acknowledge slot, or early when arbitration is lost
  assign step_done = (state_q == s_busy) && tick
                     && (arb_lost || (ph_q == p_d && (op_q != op_byte || bitn_q == 4'h8)));
  assign step_report = step_done && (op_q == op_start || op_q == op_byte);

  // start decision when the flag is cleared
  wire go = clr_step && enabled;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q      <= s_idle;
      op_q         <= op_start;
      ph_q         <= p_a;
      bitn_q       <= 4'h0;
      own_q        <= 1'b0;
      addr_phase_q <= 1'b0;
      status_q     <= st_idle;
      sda_drv_q    <= 1'b1;
      scl_drv_q    <= 1'b1;
      recv_mode    <= 1'b0;
      slave_mode   <= 1'b0;
    end else begin
      case (state_q)
        s_idle, s_hold: begin
          // flag set: nothing moves until software clears it
          if (go) begin                                               // RL21
            slave_mode <= 1'b0;
            ph_q       <= p_a;
            bitn_q     <= 4'h0;
            if (wdata[bit_stop] && own_q) begin
              op_q    <= wdata[bit_start] ? op_stop_start : op_stop;  // RL11 RL16 RL17
              state_q <= s_busy;
            end else if (wdata[bit_start]) begin
              op_q    <= op_start;
              state_q <= own_q ? s_busy : s_wait_free;                // RL4 RL15 RL19 RL20
            end else if (own_q) begin
              op_q         <= op_byte;                                // RL7 RL14
              addr_phase_q <= (status_q == st_start) || (status_q == st_rstart);
              state_q      <= s_busy;
            end else if (status_q == st_arb_lost) begin
              slave_mode <= 1'b1;                                     // RL18
              status_q   <= st_idle;
            end
          end
        end
        s_wait_free: begin
          if (!bus_busy_q && scl_s && sda_s)                          // RL4
            state_q <= s_busy;
        end
        s_busy: if (tick) begin
          ph_q <= phase_type'(ph_q + 1);
          case (op_q)
            op_start, op_stop, op_stop_start: begin
              // sda moves under a high scl only for the start or stop edge itself
              // a: set sda; b: scl high; c: sda edge; d: scl low after a start
              case (ph_q)
                p_a: begin
                  sda_drv_q <= (op_q == op_start);
                  if (op_q != op_start) scl_drv_q <= 1'b0;
                end
                p_b: scl_drv_q <= 1'b1;
                p_c: sda_drv_q <= (op_q != op_start);
                default: if (op_q == op_start) scl_drv_q <= 1'b0;
              endcase
            end
            default: begin
              // a: scl low, set bit; b: scl high; c: sample; d: scl low
              case (ph_q)
                p_a: begin
                  scl_drv_q <= 1'b0;
                  sda_drv_q <= (bitn_q == 4'h8) ? 1'b1 : data_q[3'(7 - bitn_q)];
                end
                p_b: scl_drv_q <= 1'b1;
                p_c: if (!scl_s) ph_q <= p_c;                          // clock stretch
                     else if (bitn_q == 4'h8) ack_q <= !sda_s;
                default: begin
                  scl_drv_q <= 1'b0;
                  if (bitn_q != 4'h8) begin
                    bitn_q <= bitn_q + 4'h1;
                    ph_q   <= p_a;
                  end
                end
              endcase
            end
          endcase
          if (step_done) begin
            state_q <= s_hold;
            if (arb_lost) begin
              status_q  <= st_arb_lost;                               // RL18
              own_q     <= 1'b0;
              sda_drv_q <= 1'b1;
              scl_drv_q <= 1'b1;
            end else case (op_q)
              op_start: begin
                status_q <= own_q ? st_rstart : st_start;             // RL1 RL5 RL12
                own_q    <= 1'b1;
                recv_mode <= 1'b0;
              end
              op_stop: begin
                own_q    <= 1'b0;                                     // RL11
                status_q <= st_idle;
                state_q  <= s_idle;
              end
              op_stop_start: begin
                own_q   <= 1'b0;                                      // RL17
                op_q    <= op_start;
                ph_q    <= p_a;
                state_q <= s_wait_free;
              end
              default: if (addr_phase_q && data_q[0]) begin
                status_q  <= ack_q ? st_rx_addr_ack : st_rx_addr_nack;
                recv_mode <= 1'b1;                                    // RL13
              end else if (addr_phase_q) begin
                status_q <= ack_q ? st_addr_ack : st_addr_nack;       // RL8
              end else begin
                status_q <= ack_q ? st_data_ack : st_data_nack;       // RL14
              end
            endcase
          end
        end
        default: state_q <= s_idle;
      endcase
    end
  end

  // open-drain: drive low only
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = !scl_drv_q;
  assign sda_oe  = !sda_drv_q;

  ////////////////////////////////////////////////////////////////
  flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
    step_report |=> ctrl_q[bit_step]) else $error("flag not set");  // RL5
  clr_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    (clr_step && !step_report) |=> !ctrl_q[bit_step]) else $error("flag not cleared"); // RL6
  wcol_set_a: assert property (@(posedge clk) disable iff (!nrst)
    (data_wr && !ctrl_q[bit_step]) |=> ctrl_q[bit_wcol] && $stable(data_q))
    else $error("collision missed"); // RL10
  hold_bus_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == s_hold && !go) |=> state_q == s_hold) else $error("moved while held"); // RL21
  start_code_a: assert property (@(posedge clk) disable iff (!nrst)
    (step_done && op_q == op_start && !own_q && !arb_lost) |=> status_q == st_start)
    else $error("bad start code"); // RL5
  rstart_code_a: assert property (@(posedge clk) disable iff (!nrst)
    (step_done && op_q == op_start && own_q && !arb_lost) |=> status_q == st_rstart)
    else $error("bad restart code"); // RL12
  free_start_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == s_wait_free && bus_busy_q) |=> state_q == s_wait_free)
    else $error("start on busy bus"); // RL4
  stop_clr_a: assert property (@(posedge clk) disable iff (!nrst)
    (step_done && (op_q == op_stop || op_q == op_stop_start)) |=> !ctrl_q[bit_stop] && !own_q)
    else $error("stop bit kept"); // RL16
  arb_code_a: assert property (@(posedge clk) disable iff (!nrst)
    arb_lost |=> status_q == st_arb_lost && !own_q) else $error("arb code"); // RL18
  prescale_a: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == status_addr) |=> rdata[2:0] == prescale_rst) else $error("prescale"); // RL2
endmodule
`default_nettype wire

// ### verification/tw_slave_model.sv
// behavioural slave receiver on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tw_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack,
  output logic            sda_pull,
  output logic [7:0]      last_byte
);
  int         bits;
  logic [7:0] shift;
  initial begin
    sda_pull = 1'b0;
    bits = 0;
    shift = 8'h00;
    last_byte = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // start or repeated start restarts framing
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bits = 0;
    end
  end
  // msb first; ninth clock is the acknowledge slot
  always @(posedge scl) begin
    if (bits < 8) begin
      shift = {shift[6:0], sda};
    end
    bits = bits + 1;
    if (bits == 8) begin
      last_byte = shift;
    end
  end
  // pull low only for the acknowledge bit, released pin floats high
  always @(negedge scl) begin
    sda_pull = (bits == 8) && !nack;
    if (bits == 9) begin
      bits = 0;
    end
  end
endmodule
`default_nettype wire

// ### verification/two_wire_master_transmit_test.sv
// self-checking bench for the two-wire master-send block
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_transmit_test import tw_pkg::*;;
  logic       clk;
  logic       nrst;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       scl_oe;
  logic       sda_oe;
  logic       recv_mode;
  logic       slv_pull;
  logic       rival;
  logic       slave_mode;
  logic       nack;
  logic [7:0] slv_byte;
  logic [7:0] rv;
  int         fails;
  int         checks_done;
  // open-drain wires with pull-ups
  wire logic  scl_w = ~scl_oe;
  // rival stands for a competing master holding sda low
  wire logic  sda_w = ~(sda_oe | slv_pull | rival);

  tw_master_send i_tw_master_send (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .recv_mode(recv_mode),
    .slave_mode(slave_mode));
  tw_slave_model i_tw_slave_model (.scl(scl_w), .sda(sda_w), .nack(nack),
    .sda_pull(slv_pull), .last_byte(slv_byte));

  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // extra edge after each strobe so no strobe is assigned twice in a step
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic wait_bit(input int b, input logic lvl);
    int n;
    n = 0;
    rd_reg(ctrl_addr, rv);
    while (rv[b] !== lvl && n < 4000) begin
      rd_reg(ctrl_addr, rv);
      n++;
    end
    if (rv[b] !== lvl) begin
      fails++;
      complete_run();
    end
  endtask
  // optional data load, control write, then wait for the step and check status
  task automatic go(input logic load, input logic [7:0] d, input logic [7:0] c,
                    input logic [7:0] st);
    if (load) begin
      wr_reg(data_addr, d);
    end
    wr_reg(ctrl_addr, c);
    wait_bit(bit_step, 1'b1);
    rd_reg(status_addr, rv);
    check8(rv & status_mask, st);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    nack = 1'b0;
    rival = 1'b0;
    rv = 8'h00;
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_reg(ctrl_addr, rv);
    check8(rv, ctrl_reset);
    rd_reg(status_addr, rv);
    check8(rv, st_idle);
    wr_reg(data_addr, 8'h77);
    rd_reg(ctrl_addr, rv);
    check8({7'h00, rv[bit_wcol]}, 8'h01);
    $display("test reset_and_collision done");
    go(1'b0, 8'h00, 8'ha4, st_start);
    go(1'b1, 8'ha0, 8'h84, st_addr_ack);
    check8(slv_byte, 8'ha0);
    check8({7'h00, recv_mode}, 8'h00);
    // flag left set: nothing may move on the bus meanwhile
    repeat (300) @(posedge clk);
    rd_reg(status_addr, rv);
    check8(rv, st_addr_ack);
    go(1'b1, 8'h5a, 8'h84, st_data_ack);
    check8(slv_byte, 8'h5a);
    nack <= 1'b1;
    go(1'b1, 8'hc3, 8'h84, st_data_nack);
    $display("test send_bytes done");
    go(1'b0, 8'h00, 8'hb4, st_start);
    rd_reg(ctrl_addr, rv);
    check8({7'h00, rv[bit_stop]}, 8'h00);
    go(1'b1, 8'ha0, 8'h84, st_addr_nack);
    nack <= 1'b0;
    wr_reg(ctrl_addr, 8'h94);
    wait_bit(bit_stop, 1'b0);
    check8({6'h00, scl_w, sda_w}, 8'h03);
    $display("test stop done");
    go(1'b0, 8'h00, 8'ha4, st_start);
    go(1'b1, 8'ha4, 8'h84, st_addr_ack);
    go(1'b0, 8'h00, 8'ha4, st_rstart);
    go(1'b1, 8'ha1, 8'h84, st_rx_addr_ack);
    check8(slv_byte, 8'ha1);
    check8({7'h00, recv_mode}, 8'h01);
    $display("test repeated_start done");
    wr_reg(ctrl_addr, 8'h94);
    wait_bit(bit_stop, 1'b0);
    go(1'b0, 8'h00, 8'ha4, st_start);
    check8({7'h00, recv_mode}, 8'h00);
    // rival holds sda low for the whole byte, so the first one bit is lost
    rival <= 1'b1;
    go(1'b1, 8'ha0, 8'h84, st_arb_lost);
    rival <= 1'b0;
    wr_reg(ctrl_addr, 8'h84);
    rd_reg(status_addr, rv);
    check8(rv & status_mask, st_idle);
    check8({7'h00, slave_mode}, 8'h01);
    go(1'b0, 8'h00, 8'ha4, st_start);
    check8({7'h00, slave_mode}, 8'h00);
    $display("test arbitration done");
    complete_run();
  end
endmodule
`default_nettype wire
